// ---- src/rirq_top.sv ----
`timescale 1ns/100ps
// interrupt status and mask registers of the reader
module rirq_top (
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_reset,
   input  wire logic       i_set_default,
   // register port
   input  wire logic [5:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_rd,
   output logic      [7:0] o_reg_rdata,
   // main events, one-cycle pulses
   input  wire logic       i_osc_stable,
   input  wire logic       i_fifo_level_flag,
   input  wire logic       i_rx_start,
   input  wire logic       i_rx_end,
   input  wire logic       i_tx_end,
   input  wire logic       i_bit_collision,
   // timer and field events, one-cycle pulses
   input  wire logic       i_cmd_done,
   input  wire logic       i_noresp_expired,
   input  wire logic       i_gp_timer_expired,
   input  wire logic       i_field_on,
   input  wire logic       i_field_off,
   input  wire logic       i_ca_collision,
   input  wire logic       i_guard_done,
   input  wire logic       i_bitrate_found,
   // error and wake-up events, one-cycle pulses
   input  wire logic       i_crc_error,
   input  wire logic       i_parity_error,
   input  wire logic       i_soft_framing,
   input  wire logic       i_hard_framing,
   input  wire logic       i_wake_timer,
   input  wire logic       i_wake_amplitude,
   input  wire logic       i_wake_phase,
   input  wire logic       i_wake_capacitance,
   // interrupt request
   output logic            o_irq
);
   import rirq_pkg::*;

   // address match, used by both read and write decoding
   function automatic logic addr_hit(input logic [5:0] a,
                                     input logic [5:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   logic [7:0] main_mask_q;
   logic [7:0] main_mask_d;
   logic [7:0] timer_mask_q;
   logic [7:0] timer_mask_d;
   logic [7:0] err_mask_q;
   logic [7:0] err_mask_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       irq_q;
   logic       irq_d;

   logic [RIRQ_MAIN_EVT_W-1:0] main_evt;
   logic [RIRQ_MAIN_EVT_W-1:0] main_set;
   logic [RIRQ_SUM_W-1:0]      sum_flags;
   logic [RIRQ_SUM_W-1:0]      sum_set;
   logic [RIRQ_SUM_W-1:0]      sum_clr;
   logic [7:0]                 timer_evt;
   logic [7:0]                 timer_set;
   logic [7:0]                 err_evt;
   logic [7:0]                 err_set;
   logic [7:0]                 main_view;
   logic                       rd_main;
   logic                       rd_timer;
   logic                       rd_err;

   // read strobes for the clear-on-read registers
   assign rd_main  = i_reg_rd && addr_hit(i_reg_addr, RIRQ_MAIN_STAT_ADDR);
   assign rd_timer = i_reg_rd && addr_hit(i_reg_addr, RIRQ_TIMER_STAT_ADDR);
   assign rd_err   = i_reg_rd && addr_hit(i_reg_addr, RIRQ_ERR_STAT_ADDR);

   // main event sources, bit 5 of this vector is status bit 7
   assign main_set = {i_osc_stable,      // R04
                      i_fifo_level_flag, // R05
                      i_rx_start,        // R06
                      i_rx_end,
                      i_tx_end,
                      i_bit_collision};

   assign timer_set = {i_cmd_done,         // R10
                       i_noresp_expired,
                       i_gp_timer_expired,
                       i_field_on,         // R11
                       i_field_off,
                       i_ca_collision,     // R12
                       i_guard_done,       // R13
                       i_bitrate_found};   // R14

   assign err_set = {i_crc_error,          // R16
                     i_parity_error,
                     i_soft_framing,
                     i_hard_framing,
                     i_wake_timer,
                     i_wake_amplitude,
                     i_wake_phase,
                     i_wake_capacitance};

   // main bits 7..2, cleared by a read of the main register
   rirq_flag_reg #(
      .W (RIRQ_MAIN_EVT_W)
   ) u_main_flags (
      .i_mclk        (i_mclk),
      .i_reset       (i_reset),
      .i_set_default (i_set_default),   // R09
      .i_clear       (rd_main),         // R08
      .i_set         (main_set),
      .o_flags       (main_evt)
   );

   // timer detail register; a main read empties it
   rirq_flag_reg #(
      .W (8)
   ) u_timer_flags (
      .i_mclk        (i_mclk),
      .i_reset       (i_reset),
      .i_set_default (i_set_default),   // R09
      .i_clear       (rd_main),         // R15
      .i_set         (timer_set),
      .o_flags       (timer_evt)
   );

   // error detail register; a main read empties it too
   rirq_flag_reg #(
      .W (8)
   ) u_err_flags (
      .i_mclk        (i_mclk),
      .i_reset       (i_reset),
      .i_set_default (i_set_default),
      .i_clear       (rd_main),         // R16
      .i_set         (err_set),
      .o_flags       (err_evt)
   );

   // summary bits survive a main read and clear on their detail read,
   // so the host can still tell which detail register to fetch
   assign sum_set = {(|timer_set), (|err_set)};                 // R07
   assign sum_clr = {rd_timer, rd_err};                          // R08

   generate
      for (genvar g = 0; g < RIRQ_SUM_W; g++) begin : g_sum
         rirq_flag_reg #(
            .W (1)
         ) u_sum (
            .i_mclk        (i_mclk),
            .i_reset       (i_reset),
            .i_set_default (i_set_default),
            .i_clear       (sum_clr[g]),
            .i_set         (sum_set[g]),
            .o_flags       (sum_flags[g])
         );
      end
   endgenerate

   assign main_view = {main_evt, sum_flags};

   // mask registers; set default returns them to all zero
   always_comb begin
      main_mask_d  = main_mask_q;
      timer_mask_d = timer_mask_q;
      err_mask_d   = err_mask_q;
      if (i_set_default) begin
         main_mask_d  = RIRQ_MASK_RESET;
         timer_mask_d = RIRQ_MASK_RESET;
         err_mask_d   = RIRQ_MASK_RESET;                          // R03
      end else if (i_reg_wr) begin
         if (addr_hit(i_reg_addr, RIRQ_MAIN_MASK_ADDR)) begin
            main_mask_d = i_reg_wdata & RIRQ_MAIN_MASK_USED;     // R18
         end
         if (addr_hit(i_reg_addr, RIRQ_TIMER_MASK_ADDR)) begin
            timer_mask_d = i_reg_wdata;                          // R17
         end
         if (addr_hit(i_reg_addr, RIRQ_ERR_MASK_ADDR)) begin
            err_mask_d = i_reg_wdata;                            // R01
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         main_mask_q  <= RIRQ_MASK_RESET;
         timer_mask_q <= RIRQ_MASK_RESET;
         err_mask_q   <= RIRQ_MASK_RESET;                         // R03
      end else begin
         main_mask_q  <= main_mask_d;
         timer_mask_q <= timer_mask_d;
         err_mask_q   <= err_mask_d;
      end
   end

   // read data is captured before the clear takes effect
   always_comb begin
      rdata_d = rdata_q;
      if (i_reg_rd) begin
         case (i_reg_addr)
            RIRQ_MAIN_MASK_ADDR:  rdata_d = main_mask_q;
            RIRQ_TIMER_MASK_ADDR: rdata_d = timer_mask_q;
            RIRQ_ERR_MASK_ADDR:   rdata_d = err_mask_q;
            RIRQ_MAIN_STAT_ADDR:  rdata_d = main_view;
            RIRQ_TIMER_STAT_ADDR: rdata_d = timer_evt;
            RIRQ_ERR_STAT_ADDR:   rdata_d = err_evt;
            default:              rdata_d = 8'h00;
         endcase
      end
   end

   // one mask bit per event; a one hides that event from the pin
   always_comb begin
      irq_d = (|(main_evt & ~main_mask_q[7:RIRQ_MAIN_EVT_LSB]))   // R18
            | (|(timer_evt & ~timer_mask_q))                       // R17
            | (|(err_evt & ~err_mask_q));                          // R01 R02
   end

   // registered so the pin never glitches on decode; costs one cycle
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         rdata_q <= RIRQ_STAT_RESET;
         irq_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         irq_q   <= irq_d;                                         // R19
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_irq       = irq_q;
endmodule : rirq_top

// ---- src/rirq_pkg.sv ----
// Notes on behaviour
// [R01] error mask bits 7..4 gate crc, parity, soft and hard framing requests
// [R02] error mask bits 3..0 gate wake timer, amplitude, phase, capacitance
// [R03] error mask reads zero after power-up and after set default
// [R04] main bit 7 sets when the oscillator becomes stable after enabling
// [R05] main bit 6 sets on fifo water level during receive or transmit
// [R06] main bits 5..2 flag receive start and end, transmit end, collision
// [R07] main bit 1 flags timer events pending, bit 0 error events pending
// [R08] reading main clears bits 7..2; bits 1,0 clear on detail read
// [R09] main and timer registers clear at power-up and set default
// [R10] timer bits 7..5 flag command done, no-response, general timer expiry
// [R11] timer bit 4 flags field rising, bit 3 field falling
// [R12] timer bit 2 flags external field seen during collision avoidance
// [R13] timer bit 1 flags guard time elapsed after own field switched on
// [R14] timer bit 0 flags initiator bit rate recognised in target mode
// [R15] timer register clears when main register is read
// [R16] error register holds crc, parity, framing and wake-up flags
// [R17] timer mask register gates each timer event, one masks
// [R18] main mask register gates the six main events, one masks
// [R19] interrupt output active while any unmasked flag is set
// [R20] host reads main first, then the detail register it points to
package rirq_pkg;
   // register addresses on the 6-bit register port
   localparam logic [5:0] RIRQ_MAIN_MASK_ADDR  = 6'h14;
   localparam logic [5:0] RIRQ_TIMER_MASK_ADDR = 6'h15;
   localparam logic [5:0] RIRQ_ERR_MASK_ADDR   = 6'h16;
   localparam logic [5:0] RIRQ_MAIN_STAT_ADDR  = 6'h17;
   localparam logic [5:0] RIRQ_TIMER_STAT_ADDR = 6'h18;
   localparam logic [5:0] RIRQ_ERR_STAT_ADDR   = 6'h19;

   // values after power-up and after set default
   localparam logic [7:0] RIRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] RIRQ_STAT_RESET = 8'h00;

   // main register field positions
   localparam int RIRQ_MAIN_OSC_BIT   = 7;
   localparam int RIRQ_MAIN_LEVEL_BIT = 6;
   localparam int RIRQ_MAIN_EVT_LSB   = 2;   // bits 7..2 are own events
   localparam int RIRQ_MAIN_TIM_BIT   = 1;
   localparam int RIRQ_MAIN_ERR_BIT   = 0;
   localparam int RIRQ_MAIN_EVT_W     = 6;
   localparam int RIRQ_SUM_W          = 2;

   // bits kept in the main mask register; bits 1..0 read as zero
   localparam logic [7:0] RIRQ_MAIN_MASK_USED = 8'hFC;
endpackage : rirq_pkg

// ---- src/rirq_flag_reg.sv ----
`timescale 1ns/100ps
// sticky event flags: an event in the clearing cycle survives the clear
module rirq_flag_reg #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_reset,
   // control
   input  wire logic         i_set_default,
   input  wire logic         i_clear,
   input  wire logic [W-1:0] i_set,
   // state
   output logic      [W-1:0] o_flags
);
   import rirq_pkg::*;

   logic [W-1:0] flags_q;
   logic [W-1:0] flags_d;

   // set wins over clear so no event is dropped on a read
   always_comb begin
      flags_d = flags_q;
      if (i_set_default) begin
         flags_d = W'(RIRQ_STAT_RESET);
      end else if (i_clear) begin
         flags_d = W'(RIRQ_STAT_RESET);
      end
      flags_d = flags_d | i_set;
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         flags_q <= W'(RIRQ_STAT_RESET);
      end else begin
         flags_q <= flags_d;
      end
   end

   assign o_flags = flags_q;
endmodule : rirq_flag_reg

// ---- tb/rirq_asserts.sv ----
`timescale 1ns/100ps
// port-level checks of the interrupt status block
module rirq_asserts (
   // clock, reset and register port
   input wire logic       i_mclk,
   input wire logic       i_reset,
   input wire logic       i_set_default,
   input wire logic [5:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   // events and request
   input wire logic       i_osc_stable,
   input wire logic       i_cmd_done,
   input wire logic       i_crc_error,
   input wire logic       i_wake_capacitance,
   input wire logic       o_irq
);
   default clocking dc @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   // register port after reset and set default, error mask readback, main mask low bits
   property p_rst_quiet;
      $fell(i_reset) |-> !o_irq && o_reg_rdata == 8'h00;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet");
   property p_dflt_mask;
      i_set_default ##1 !i_reg_wr ##1 (i_reg_rd && i_reg_addr == 6'h16)
         |=> o_reg_rdata == 8'h00;
   endproperty
   a_dflt_mask: assert property (p_dflt_mask) else $error("mask kept");
   property p_mask_rb;
      (i_reg_wr && i_reg_addr == 6'h16 && !i_set_default) ##1
         (!i_reg_wr && !i_set_default) ##1 (i_reg_rd && i_reg_addr == 6'h16)
         |=> o_reg_rdata == $past(i_reg_wdata, 3);
   endproperty
   a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
   property p_main_low;
      i_reg_rd && i_reg_addr == 6'h14 |=> o_reg_rdata[1:0] == 2'b00;
   endproperty
   a_main_low: assert property (p_main_low) else $error("low bits");
   // masks are zero after set default, so the osc, cmd, crc and capacitance events must each raise the request
   property p_osc_irq;
      i_set_default ##1 !i_reg_wr ##1 (i_osc_stable && !i_reg_wr
         && !i_set_default) ##1 !i_set_default |=> o_irq;
   endproperty
   a_osc_irq: assert property (p_osc_irq) else $error("osc irq");
   property p_cmd_irq;
      i_set_default ##1 !i_reg_wr ##1 (i_cmd_done && !i_reg_wr
         && !i_set_default) ##1 !i_set_default |=> o_irq;
   endproperty
   a_cmd_irq: assert property (p_cmd_irq) else $error("cmd irq");
   property p_crc_irq;
      i_set_default ##1 !i_reg_wr ##1 (i_crc_error && !i_reg_wr
         && !i_set_default) ##1 !i_set_default |=> o_irq;
   endproperty
   a_crc_irq: assert property (p_crc_irq) else $error("crc irq");
   property p_cap_irq;
      i_set_default ##1 !i_reg_wr ##1 (i_wake_capacitance && !i_reg_wr
         && !i_set_default) ##1 !i_set_default |=> o_irq;
   endproperty
   a_cap_irq: assert property (p_cap_irq) else $error("cap irq");
endmodule : rirq_asserts

bind rirq_top rirq_asserts chk_u (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_set_default(i_set_default),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_irq(o_irq),
   .i_osc_stable(i_osc_stable), .i_cmd_done(i_cmd_done),
   .i_crc_error(i_crc_error), .i_wake_capacitance(i_wake_capacitance)
);

// ---- tb/rirq_host.sv ----
`timescale 1ns/100ps
// host side of the register port; one idle cycle after every transfer
module rirq_host (
   // clock and read data
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_rdata,
   // requests
   output logic      [5:0] o_addr,
   output logic            o_wr,
   output logic      [7:0] o_wdata,
   output logic            o_rd,
   output logic            o_sdef
);
   // idle port at time zero
   initial begin
      o_addr = 6'h00;
      o_wr = 1'b0;
      o_wdata = 8'h00;
      o_rd = 1'b0;
      o_sdef = 1'b0;
   end
   // released data shows the inverse so a stale byte is never reused
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_mclk) o_wr <= 1'b0;
      o_wdata <= ~d;
      @(posedge i_mclk);
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_mclk) o_rd <= 1'b0;
      @(negedge i_mclk) d = i_rdata;
      @(posedge i_mclk);
   endtask : rd
   task automatic sdef();
      o_sdef <= 1'b1;
      @(posedge i_mclk) o_sdef <= 1'b0;
      @(posedge i_mclk);
   endtask : sdef
endmodule : rirq_host

// ---- tb/rirq_top_tb_top.sv ----
`timescale 1ns/100ps
// bench for the interrupt status and mask block
module rirq_top_tb_top;
   logic        i_mclk = 1'b0;
   logic        i_reset = 1'b1;
   logic        sdef, wr, rd, irq;
   logic [5:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [21:0] ev = '0;
   int          n_errors, comparisons, k;
   int          tbl [4] = '{21, 15, 7, 0};

   always #20 i_mclk = ~i_mclk;

   rirq_top dut_u (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_set_default(sdef),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
      .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq),
      .i_osc_stable(ev[21]), .i_fifo_level_flag(ev[20]),
      .i_rx_start(ev[19]), .i_rx_end(ev[18]), .i_tx_end(ev[17]),
      .i_bit_collision(ev[16]), .i_cmd_done(ev[15]),
      .i_noresp_expired(ev[14]), .i_gp_timer_expired(ev[13]),
      .i_field_on(ev[12]), .i_field_off(ev[11]), .i_ca_collision(ev[10]),
      .i_guard_done(ev[9]), .i_bitrate_found(ev[8]),
      .i_crc_error(ev[7]), .i_parity_error(ev[6]), .i_soft_framing(ev[5]),
      .i_hard_framing(ev[4]), .i_wake_timer(ev[3]),
      .i_wake_amplitude(ev[2]), .i_wake_phase(ev[1]),
      .i_wake_capacitance(ev[0])
   );
   rirq_host host_u (
      .i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
      .o_wdata(wdata), .o_rd(rd), .o_sdef(sdef)
   );

   // comparisons and transfer helpers
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t irq %h exp %h", $time, got, exp);
      end
   endtask : chk1
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_u.rd(a, d);
      chk8(d, exp);
   endtask : rdc
   task automatic fire(input logic [21:0] v);
      ev <= v;
      @(posedge i_mclk) ev <= '0;
      @(posedge i_mclk);
   endtask : fire
   task automatic irq_is(input logic exp);
      @(negedge i_mclk) chk1(irq, exp);
      @(posedge i_mclk);
   endtask : irq_is
   task automatic test_done();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   // hang guard, more than ten times the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge i_mclk);
      n_errors++;
      test_done();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      for (k = 20; k <= 25; k++) rdc(k[5:0], 8'h00);
      rdc(6'h2A, 8'h00);
      for (k = 0; k < 6; k++) begin
         fire(22'h1 << (16 + k));
         irq_is(1'b1);
         rdc(6'h17, 8'(8'h04 << k));
         irq_is(1'b0);
         rdc(6'h17, 8'h00);
      end
      for (k = 0; k < 8; k++) begin
         fire(22'h100 << k);
         rdc(6'h18, 8'(8'h01 << k));
         rdc(6'h17, 8'h00);
         irq_is(1'b0);
         fire(22'h100 << k);
         rdc(6'h17, 8'h02);
         rdc(6'h18, 8'h00);
      end
      for (k = 0; k < 8; k++) begin
         host_u.wr(6'h16, 8'(8'h01 << k));
         fire(22'h1 << k);
         irq_is(1'b0);
         rdc(6'h16, 8'(8'h01 << k));
         host_u.wr(6'h16, 8'h00);
         irq_is(1'b1);
         rdc(6'h19, 8'(8'h01 << k));
         rdc(6'h17, 8'h00);
         irq_is(1'b0);
      end
      host_u.wr(6'h16, 8'hA5);
      rdc(6'h16, 8'hA5);
      host_u.wr(6'h14, 8'hFF);
      host_u.wr(6'h15, 8'hFF);
      fire(22'h3FFF00);
      irq_is(1'b0);
      rdc(6'h14, 8'hFC);
      rdc(6'h15, 8'hFF);
      host_u.sdef();
      rdc(6'h16, 8'h00);
      rdc(6'h17, 8'h00);
      rdc(6'h18, 8'h00);
      for (k = 0; k < 4; k++) begin
         host_u.sdef();
         fire(22'h1 << tbl[k]);
         irq_is(1'b1);
      end
      host_u.sdef();
      irq_is(1'b0);
      test_done();
   end
endmodule : rirq_top_tb_top
